// ===== core/phy_line_monitor.sv
/*
 * One port's line monitor and receive modes: equalizer coefficient deviation monitor,
 * early start-of-frame receive, quiet isolation, transmit symbol coding and channel to
 * channel repeater. Assumes the coefficient, link status, symbol streams and MII transmit
 * come from logic on clk_i; only the repeater strap is an asynchronous pin.
 */
// How it works
// RULE1: On link up, latch the live coefficient as the reference.
// RULE2: Coefficient beyond the limit from the reference raises interrupt or link down.
// RULE3: Drop link only with link-drop enable and BER monitor on; interrupt when unmasked.
// RULE4: After any link down, a fresh reference is latched.
// RULE5: Limit of all ones disables the monitor and recaptures continuously; reset value.
// RULE6: Writing FFFE keeps the limit and selects reference readout; other writes leave it.
// RULE7: Readback gives live coefficient bits 17:2, or reference bits 17:2 in readout.
// RULE8: Offset 0x18 is a write-only limit and a read-only coefficient readback.
// RULE9: Comparison runs every cycle, so a change is flagged well within 9 us.
// RULE10: MII nibbles become 5-bit symbols; frames open with J 11000 then K 10001.
// RULE11: Standard receive waits for both J and K before driving MII data.
// RULE12: Early mode drives MII receive data right after the first J.
// RULE13: In early mode a non-K after J raises receive error, then the receiver drops data valid and hunts for J again.
// RULE14: Quiet isolation: no link setup and silent line until software enables the port.
// RULE15: Channel loopback forwards every frame from the other port straight out while the port enable bit is set.
// RULE16: Channel loopback is chosen by strap pin or by a control register bit.
// RULE17: Loopback with one copper and one fibre port makes a media converter.
// RULE18: With link-drop disabled a trigger only leaves the good-link state.
// RULE19: Trigger when the absolute slice difference strictly exceeds the limit.
module phy_line_monitor
	import phy_mon_pkg::*;
#(
	parameter logic QUIET_ISO_AT_RESET = 1'b1
)(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [COEF_W-1:0] eq_coef_i,
	input wire logic link_ok_i,
	input wire logic ber_trigger_i,
	input wire logic strap_c2c_loop_i,
	input wire logic peer_is_fibre_i,
	input wire line_sym_t rx_line_i,
	input wire line_sym_t peer_rx_line_i,
	input wire logic mii_tx_en_i,
	input wire logic [3:0] mii_txd_i,
	output mii_rx_t mii_rx_o,
	output line_sym_t tx_line_o,
	output logic link_enable_o,
	output logic force_link_down_o,
	output logic good_link_o,
	output logic media_converter_o,
	output logic irq_o
);

	typedef enum logic [1:0] {GL_DOWN, GL_GOOD, GL_DEGRADED} gl_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_J, TX_K, TX_DATA, TX_T, TX_R} tx_state_t;

	logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [ST_W-1:0] status_ff, nxt_status, mask_ff, nxt_mask;
	logic [15:0] limit_ff, nxt_limit;
	logic readout_ff, nxt_readout;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [SLICE_W-1:0] ref_ff, nxt_ref;
	logic link_up_ff, nxt_link_up;
	logic dev_ff, nxt_dev;
	logic drop_ff, nxt_drop;
	logic fld_ff, nxt_fld;
	gl_state_t gl_ff, nxt_gl;
	tx_state_t tx_ff, nxt_tx;
	line_sym_t txo_ff, nxt_txo;
	logic s1_ff, s2_ff, s3_ff, strap_ff, nxt_strap;
	logic req, wr_go, rd_go, link_up, loop_active, drop_allowed, sof_err;
	logic [SLICE_W-1:0] live;
	logic [SLICE_W:0] diff;
	logic [SLICE_W-1:0] abs_diff;
	logic deviation, dev_event, ber_event, link_event;
	logic [3:0] tx_nib_ff;

	// ------------------------------------------------------------------
	// Strap synchroniser and mode decode
	// ------------------------------------------------------------------
	always_comb begin
		nxt_strap = (s2_ff == s3_ff) ? s3_ff : strap_ff;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			strap_ff <= 1'b0;
		end else begin
			s1_ff <= strap_c2c_loop_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			strap_ff <= nxt_strap;
		end
	end

	assign loop_active = strap_ff | ctrl_ff[CTRL_C2C_LOOP]; // RULE16
	assign media_converter_o = loop_active & (ctrl_ff[CTRL_FIBRE] ^ peer_is_fibre_i); // RULE17
	assign drop_allowed = ctrl_ff[CTRL_LINK_DROP] & ctrl_ff[CTRL_BER_EN];
	// Quiet isolation keeps link setup off until software sets the port enable.
	assign link_enable_o = ctrl_ff[CTRL_PORT_EN] & ~drop_ff; // RULE14
	assign link_up = link_ok_i & link_enable_o;

	// ------------------------------------------------------------------
	// Coefficient monitor
	// ------------------------------------------------------------------
	assign live = eq_coef_i[SLICE_HI:SLICE_LO];
	assign diff = {1'b0, live} - {1'b0, ref_ff};
	assign abs_diff = diff[SLICE_W] ? SLICE_W'(-diff) : diff[SLICE_W-1:0]; // RULE19
	// The compare is combinational and checked every cycle. RULE9
	assign deviation = link_up_ff && link_up && limit_ff != LIMIT_DISABLED
		&& abs_diff > limit_ff; // RULE2 RULE19
	assign dev_event = deviation & ~dev_ff;
	assign ber_event = ber_trigger_i & link_up & ctrl_ff[CTRL_BER_EN];
	assign link_event = link_up ^ link_up_ff;

	always_comb begin
		nxt_link_up = link_up;
		nxt_dev = deviation;
		nxt_ref = ref_ff;
		// Recapture while down, at link up and while disabled, so the value frozen at
		// the up edge is always the one present at that time.
		if (!link_up || !link_up_ff || limit_ff == LIMIT_DISABLED) begin
			nxt_ref = live; // RULE1 RULE4 RULE5
		end
		nxt_fld = (dev_event | ber_event) & drop_allowed & ~drop_ff; // RULE3
		nxt_drop = drop_ff;
		if (nxt_fld) begin
			nxt_drop = 1'b1; // RULE3
		end else if (!link_ok_i) begin
			nxt_drop = 1'b0;
		end
		nxt_gl = gl_ff;
		case (gl_ff)
			GL_DOWN: nxt_gl = link_up ? GL_GOOD : GL_DOWN;
			GL_GOOD: begin
				if (!link_up) begin
					nxt_gl = GL_DOWN;
				end else if (dev_event || ber_event) begin
					nxt_gl = GL_DEGRADED; // RULE18
				end
			end
			GL_DEGRADED: nxt_gl = link_up ? GL_DEGRADED : GL_DOWN;
			default: nxt_gl = GL_DOWN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			link_up_ff <= 1'b0;
			dev_ff <= 1'b0;
			ref_ff <= '0;
			fld_ff <= 1'b0;
			drop_ff <= 1'b0;
			gl_ff <= GL_DOWN;
		end else begin
			link_up_ff <= nxt_link_up;
			dev_ff <= nxt_dev;
			ref_ff <= nxt_ref;
			fld_ff <= nxt_fld;
			drop_ff <= nxt_drop;
			gl_ff <= nxt_gl;
		end
	end

	assign force_link_down_o = fld_ff;
	assign good_link_o = (gl_ff == GL_GOOD);

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_ff;
	assign wr_go = avs_write_i & ack_ff;
	assign rd_go = avs_read_i & ~ack_ff;

	always_comb begin
		nxt_ack = req & ~ack_ff;
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_limit = limit_ff;
		nxt_readout = readout_ff;
		nxt_status = status_ff;
		nxt_rdata = rdata_ff;
		if (wr_go && avs_byteenable_i[0]) begin
			case (avs_address_i)
				ADDR_CTRL: nxt_ctrl = avs_writedata_i[CTRL_W-1:0];
				ADDR_MASK: nxt_mask = avs_writedata_i[ST_W-1:0];
				ADDR_STATUS: nxt_status = status_ff & ~avs_writedata_i[ST_W-1:0];
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		if (wr_go && avs_address_i == ADDR_EQMON && avs_byteenable_i[1:0] == 2'h3) begin
			if (avs_writedata_i[15:0] == LIMIT_READOUT) begin
				nxt_readout = 1'b1; // RULE6
			end else begin
				nxt_readout = 1'b0; // RULE6
				nxt_limit = avs_writedata_i[15:0]; // RULE8
			end
		end
		// Hardware set wins over a clear in the same cycle.
		nxt_status[ST_COEF] = nxt_status[ST_COEF] | dev_event; // RULE2
		nxt_status[ST_BER] = nxt_status[ST_BER] | ber_event;
		nxt_status[ST_LINK] = nxt_status[ST_LINK] | link_event;
		nxt_status[ST_SOF] = nxt_status[ST_SOF] | sof_err;
		if (rd_go) begin
			case (avs_address_i)
				ADDR_CTRL: nxt_rdata = 32'(ctrl_ff);
				ADDR_STATUS: nxt_rdata = 32'(status_ff);
				ADDR_MASK: nxt_rdata = 32'(mask_ff);
				ADDR_STATE: nxt_rdata = 32'({drop_ff, readout_ff, media_converter_o,
					loop_active, good_link_o, link_up_ff});
				ADDR_EQMON: nxt_rdata = 32'(readout_ff ? ref_ff : live); // RULE7 RULE8
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ack_ff <= 1'b0;
			ctrl_ff <= CTRL_RESET | (CTRL_W'(!QUIET_ISO_AT_RESET) << CTRL_PORT_EN);
			mask_ff <= ST_RESET;
			status_ff <= ST_RESET;
			limit_ff <= LIMIT_RESET; // RULE5
			readout_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= nxt_ack;
			ctrl_ff <= nxt_ctrl;
			mask_ff <= nxt_mask;
			status_ff <= nxt_status;
			limit_ff <= nxt_limit;
			readout_ff <= nxt_readout;
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign irq_o = |(status_ff & mask_ff); // RULE3

	// ------------------------------------------------------------------
	// Receive framer
	// ------------------------------------------------------------------
	sof_receiver u_rx (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.early_en_i(ctrl_ff[CTRL_EARLY_SOF]),
		.sym_valid_i(rx_line_i.en),
		.sym_i(rx_line_i.sym),
		.mii_rx_o(mii_rx_o),
		.sof_err_o(sof_err)
	);

	// ------------------------------------------------------------------
	// Transmit coder and repeater
	// ------------------------------------------------------------------
	always_comb begin
		nxt_tx = tx_ff;
		nxt_txo = '{en: 1'b1, sym: SYM_IDLE};
		case (tx_ff)
			TX_IDLE: begin
				if (mii_tx_en_i) begin
					nxt_tx = TX_K;
					nxt_txo.sym = SYM_J; // RULE10
				end
			end
			TX_K: begin
				nxt_tx = TX_DATA;
				nxt_txo.sym = SYM_K; // RULE10
			end
			TX_DATA: begin
				if (mii_tx_en_i) begin
					nxt_txo.sym = encode_nibble(mii_txd_i); // RULE10
				end else begin
					nxt_tx = TX_R;
					nxt_txo.sym = SYM_T;
				end
			end
			TX_R: begin
				nxt_tx = TX_IDLE;
				nxt_txo.sym = SYM_R;
			end
			default: nxt_tx = TX_IDLE;
		endcase
		if (loop_active) begin
			nxt_txo = peer_rx_line_i; // RULE15
		end
		if (!ctrl_ff[CTRL_PORT_EN]) begin
			nxt_txo = '{en: 1'b0, sym: SYM_IDLE}; // RULE14
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			tx_ff <= TX_IDLE;
			txo_ff <= '{en: 1'b0, sym: SYM_IDLE};
			tx_nib_ff <= 4'h0;
		end else begin
			tx_ff <= nxt_tx;
			txo_ff <= nxt_txo;
			tx_nib_ff <= mii_txd_i;
		end
	end

	assign tx_line_o = txo_ff;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_ref_at_up: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
		link_up && !link_up_ff |=> ref_ff == $past(live))
		else $error("reference not latched at link up");

	chk_ref_when_down: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE4
		!link_up ##1 !link_up |-> ref_ff == $past(live))
		else $error("reference not refreshed while link down");

	chk_limit_off: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
		limit_ff == LIMIT_DISABLED |=> !dev_ff && ref_ff == $past(live))
		else $error("disabled monitor still compared or held reference");

	chk_dev_to_status: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
		link_up_ff && link_up && limit_ff != LIMIT_DISABLED && abs_diff > limit_ff
		|=> status_ff[ST_COEF])
		else $error("coefficient deviation not flagged in time");

	chk_drop_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE3
		force_link_down_o |-> $past(drop_allowed) ##1 !link_enable_o)
		else $error("link forced down without drop enables");

	chk_degrade_only: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE18
		!drop_allowed && gl_ff == GL_GOOD && link_up && dev_event
		|=> gl_ff == GL_DEGRADED && !force_link_down_o)
		else $error("trigger with drop disabled did not only degrade");

	chk_readout_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE6
		wr_go && avs_address_i == ADDR_EQMON && avs_writedata_i[15:0] == LIMIT_READOUT
		&& avs_byteenable_i[1:0] == 2'h3 |=> readout_ff && $stable(limit_ff))
		else $error("readout code changed the limit");

	chk_readback: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
		rd_go && avs_address_i == ADDR_EQMON
		|=> avs_readdata_o == 32'($past(readout_ff) ? $past(ref_ff) : $past(live))
		&& !avs_waitrequest_o)
		else $error("coefficient readback wrong");

	chk_quiet_iso: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE14
		!ctrl_ff[CTRL_PORT_EN] ##1 !ctrl_ff[CTRL_PORT_EN] |-> !tx_line_o.en && !link_enable_o)
		else $error("isolated port not quiet");

	chk_loop_fwd: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE15
		loop_active && ctrl_ff[CTRL_PORT_EN] |=> tx_line_o == $past(peer_rx_line_i))
		else $error("repeater did not forward peer symbol");

endmodule

// ===== core/phy_mon_pkg.sv
/*
 * Shared constants, carriers and symbol code tables of the line monitor and receive-mode
 * port logic. Assumes a single 25 MHz clock domain for the port, its symbol streams and its
 * register bus.
 */
package phy_mon_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int DETECT_TIME_NS = 9000;
	// A longest time, so the division rounds down.
	localparam int DETECT_CYCLES = DETECT_TIME_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Coefficient layout
	// ------------------------------------------------------------------
	localparam int COEF_W = 18;
	localparam int SLICE_HI = 17;
	localparam int SLICE_LO = 2;
	localparam int SLICE_W = SLICE_HI - SLICE_LO + 1;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_EQMON = 8'h18;

	localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
	localparam logic [15:0] LIMIT_DISABLED = 16'hFFFF;
	localparam logic [15:0] LIMIT_READOUT = 16'hFFFE;

	localparam int CTRL_W = 6;
	localparam int CTRL_LINK_DROP = 0;
	localparam int CTRL_BER_EN = 1;
	localparam int CTRL_EARLY_SOF = 2;
	localparam int CTRL_PORT_EN = 3;
	localparam int CTRL_C2C_LOOP = 4;
	localparam int CTRL_FIBRE = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h03;

	localparam int ST_W = 4;
	localparam int ST_COEF = 0;
	localparam int ST_BER = 1;
	localparam int ST_LINK = 2;
	localparam int ST_SOF = 3;
	localparam logic [ST_W-1:0] ST_RESET = 4'h0;

	localparam int SV_LINK_UP = 0;
	localparam int SV_GOOD = 1;
	localparam int SV_LOOP = 2;
	localparam int SV_MEDIA = 3;
	localparam int SV_READOUT = 4;
	localparam int SV_DROP = 5;

	// ------------------------------------------------------------------
	// Line symbols
	// ------------------------------------------------------------------
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0D;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_IDLE = 5'h1F;
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;

	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] data;
	} mii_rx_t;

	typedef struct packed {
		logic en;
		logic [4:0] sym;
	} line_sym_t;

	function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
		logic [4:0] s;
		s = 5'h1E;
		case (nib)
			4'h0: s = 5'h1E;
			4'h1: s = 5'h09;
			4'h2: s = 5'h14;
			4'h3: s = 5'h15;
			4'h4: s = 5'h0A;
			4'h5: s = 5'h0B;
			4'h6: s = 5'h0E;
			4'h7: s = 5'h0F;
			4'h8: s = 5'h12;
			4'h9: s = 5'h13;
			4'hA: s = 5'h16;
			4'hB: s = 5'h17;
			4'hC: s = 5'h1A;
			4'hD: s = 5'h1B;
			4'hE: s = 5'h1C;
			default: s = 5'h1D;
		endcase
		return s;
	endfunction

	// Returns {valid, nibble}; valid is low for any non-data code.
	function automatic logic [4:0] decode_symbol(input logic [4:0] sym);
		logic [4:0] r;
		r = 5'h00;
		for (int n = 0; n < 16; n++) begin
			if (encode_nibble(4'(n)) == sym) begin
				r = {1'b1, 4'(n)};
			end
		end
		return r;
	endfunction

endpackage

// ===== core/sof_receiver.sv
/*
 * Receive framer: turns decoded line symbols into MII receive nibbles, with standard or
 * early start-of-frame detection. Assumes one symbol per clock while sym_valid_i is high.
 */
module sof_receiver
	import phy_mon_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic early_en_i,
	input wire logic sym_valid_i,
	input wire logic [4:0] sym_i,
	output mii_rx_t mii_rx_o,
	output logic sof_err_o
);

	typedef enum logic [1:0] {RX_IDLE, RX_GOT_J, RX_EARLY_J, RX_DATA} rx_state_t;

	rx_state_t state_ff, nxt_state;
	mii_rx_t rx_ff, nxt_rx;
	logic err_ff, nxt_err;
	logic [4:0] dec;

	// ------------------------------------------------------------------
	// Frame state
	// ------------------------------------------------------------------
	always_comb begin
		dec = decode_symbol(sym_i);
		nxt_state = state_ff;
		nxt_rx = '0;
		nxt_err = 1'b0;
		if (sym_valid_i) begin
			case (state_ff)
				RX_IDLE: begin
					if (sym_i == SYM_J && early_en_i) begin
						nxt_state = RX_EARLY_J; // RULE12
						nxt_rx = '{dv: 1'b1, er: 1'b0, data: NIB_PREAMBLE}; // RULE12
					end else if (sym_i == SYM_J) begin
						nxt_state = RX_GOT_J; // RULE11
					end
				end
				RX_GOT_J: begin
					if (sym_i == SYM_K) begin
						nxt_state = RX_DATA; // RULE11
						nxt_rx = '{dv: 1'b1, er: 1'b0, data: NIB_PREAMBLE};
					end else begin
						nxt_state = RX_IDLE;
					end
				end
				RX_EARLY_J: begin
					if (sym_i == SYM_K) begin
						nxt_state = RX_DATA;
						nxt_rx = '{dv: 1'b1, er: 1'b0, data: NIB_PREAMBLE};
					end else begin
						// A J caused by a bit error: flag it and go back to hunting.
						nxt_state = RX_IDLE; // RULE13
						nxt_rx = '{dv: 1'b1, er: 1'b1, data: 4'h0}; // RULE13
						nxt_err = 1'b1; // RULE13
					end
				end
				RX_DATA: begin
					if (sym_i == SYM_T || sym_i == SYM_IDLE) begin
						nxt_state = RX_IDLE;
					end else begin
						nxt_rx = '{dv: 1'b1, er: ~dec[4], data: dec[3:0]};
					end
				end
				default: nxt_state = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_ff <= RX_IDLE;
			rx_ff <= '0;
			err_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			rx_ff <= nxt_rx;
			err_ff <= nxt_err;
		end
	end

	assign mii_rx_o = rx_ff;
	assign sof_err_o = err_ff;

	chk_early_bad_k: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE13
		state_ff == RX_EARLY_J && sym_valid_i && sym_i != SYM_K
		|=> mii_rx_o.er && mii_rx_o.dv && sof_err_o ##1 !mii_rx_o.dv)
		else $error("bad symbol after early J did not raise receive error");

	chk_std_needs_k: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
		!early_en_i && state_ff == RX_IDLE && sym_valid_i && sym_i == SYM_J |=> !mii_rx_o.dv)
		else $error("standard mode drove receive data before K");

endmodule

// ===== sim/mac_model.sv
/*
 * Behavioural MAC on the MII side of the port: sends short frames and records what the
 * port hands back on MII receive. Assumes the port's 25 MHz clk_i and phy_mon_pkg.
 */
module mac_model
	import phy_mon_pkg::*;
(
	input wire logic clk_i,
	input wire mii_rx_t rx_i,
	output logic tx_en_o,
	output logic [3:0] txd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc;
	int dv_cyc;
	int nib_left;
	logic er_seen;

	initial begin
		tx_en_o <= 1'b0;
		txd_o <= 4'h0;
		cyc <= 0;
		dv_cyc <= -1;
		nib_left <= 0;
		er_seen <= 1'b0;
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (rx_i.dv === 1'b1 && dv_cyc < 0) begin
			dv_cyc <= cyc;
		end
		if (rx_i.er === 1'b1) begin
			er_seen <= 1'b1;
		end
		tx_en_o <= (nib_left > 0);
		// Between frames the data lines carry no meaning, so they toggle.
		txd_o <= (nib_left > 0) ? NIB_PREAMBLE : ~txd_o;
		if (nib_left > 0) begin
			nib_left <= nib_left - 1;
		end
	end

	task automatic send(input int n);
		nib_left <= n;
	endtask

	task automatic clear();
		dv_cyc <= -1;
		er_seen <= 1'b0;
	endtask
endmodule

// ===== sim/test_phy_line_monitor.sv
/*
 * Self-checking bench of phy_line_monitor: Avalon-MM register tasks and scenario calls.
 * Assumes phy_mon_pkg and mac_model are compiled before it.
 */
module test_phy_line_monitor
	import phy_mon_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_b_i, avs_read_i, avs_write_i, link_ok_i, peer_is_fibre_i, mac_en;
	logic strap_c2c_loop_i, good_link_o;
	logic [7:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [17:0] eq_coef_i;
	logic [3:0] mac_d;
	logic avs_waitrequest_o, link_enable_o, force_link_down_o, irq_o, media_converter_o;
	line_sym_t rx_line_i, peer_rx_line_i, tx_line_o;
	mii_rx_t mii_rx_o;
	int err_total, cmp_count, n, lat_std, lat_early;

	phy_line_monitor phy_line_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.eq_coef_i(eq_coef_i), .link_ok_i(link_ok_i), .ber_trigger_i(1'b0),
		.strap_c2c_loop_i(strap_c2c_loop_i),
		.peer_is_fibre_i(peer_is_fibre_i), .rx_line_i(rx_line_i),
		.peer_rx_line_i(peer_rx_line_i), .mii_tx_en_i(mac_en), .mii_txd_i(mac_d),
		.mii_rx_o(mii_rx_o), .tx_line_o(tx_line_o), .link_enable_o(link_enable_o),
		.force_link_down_o(force_link_down_o), .good_link_o(good_link_o),
		.media_converter_o(media_converter_o), .irq_o(irq_o));
	mac_model mac (.clk_i(clk_i), .rx_i(mii_rx_o), .tx_en_o(mac_en), .txd_o(mac_d));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp);
		int k;
		k = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		do begin
			@(posedge clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 40);
		chk(32'(avs_waitrequest_o), 32'h0);
		if (!wr) begin
			chk(avs_readdata_o, exp);
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic put(input logic [4:0] s);
		rx_line_i <= '{en: 1'b1, sym: s};
		@(posedge clk_i);
	endtask

	task automatic frame(output int lat);
		int t0;
		mac.clear();
		t0 = mac.cyc;
		put(SYM_J);
		put(SYM_K);
		put(5'h0B);
		put(SYM_T);
		put(SYM_IDLE);
		repeat (3) @(posedge clk_i);
		lat = mac.dv_cyc - t0;
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Clock, watchdog and scenarios
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		#100000;
		err_total++;
		final_report();
	end

	initial begin
		err_total = 0;
		cmp_count = 0;
		rst_b_i = 1'b0;
		avs_address_i = 8'h00;
		avs_writedata_i = 32'h0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		link_ok_i = 1'b0;
		peer_is_fibre_i = 1'b0;
		strap_c2c_loop_i = 1'b0;
		eq_coef_i = 18'h00100;
		rx_line_i = '{en: 1'b0, sym: SYM_IDLE};
		peer_rx_line_i = '{en: 1'b0, sym: SYM_IDLE};
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		bus(1'b0, ADDR_CTRL, 32'h0, 32'h03);
		bus(1'b0, ADDR_EQMON, 32'h0, 32'h40);
		mac.send(6);
		repeat (4) @(posedge clk_i);
		chk({30'h0, tx_line_o.en, link_enable_o}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h0B, 32'h0);
		mac.send(6);
		n = 0;
		while (tx_line_o.sym !== SYM_J && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(tx_line_o.sym), 32'(SYM_J));
		@(posedge clk_i);
		chk(32'(tx_line_o.sym), 32'(SYM_K));
		bus(1'b1, ADDR_MASK, 32'h01, 32'h0);
		bus(1'b1, ADDR_EQMON, 32'h04, 32'h0);
		link_ok_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		bus(1'b1, ADDR_EQMON, 32'hFFFE, 32'h0);
		bus(1'b0, ADDR_EQMON, 32'h0, 32'h40);
		eq_coef_i <= 18'h00110;
		repeat (4) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		eq_coef_i <= 18'h00114;
		n = 0;
		while (force_link_down_o !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, force_link_down_o}, 32'h1);
		@(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		bus(1'b1, ADDR_STATUS, 32'h0F, 32'h0);
		@(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b0, ADDR_EQMON, 32'h0, 32'h45);
		link_ok_i <= 1'b0;
		frame(lat_std);
		bus(1'b1, ADDR_CTRL, 32'h0F, 32'h0);
		frame(lat_early);
		chk(32'(lat_std - lat_early), 32'h1);
		mac.clear();
		put(SYM_J);
		put(5'h0B);
		put(SYM_IDLE);
		repeat (3) @(posedge clk_i);
		chk({31'h0, mac.er_seen}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h0B, 32'h0);
		mac.clear();
		put(SYM_J);
		put(5'h0B);
		put(SYM_IDLE);
		repeat (3) @(posedge clk_i);
		chk(32'(mac.dv_cyc), 32'hFFFFFFFF);
		bus(1'b1, ADDR_CTRL, 32'h1B, 32'h0);
		peer_is_fibre_i <= 1'b1;
		strap_c2c_loop_i <= 1'b1;
		peer_rx_line_i <= '{en: 1'b1, sym: 5'h0B};
		repeat (2) @(posedge clk_i);
		chk(32'(tx_line_o), 32'h2B);
		chk({31'h0, media_converter_o}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h0B, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(32'(tx_line_o), 32'h2B);
		strap_c2c_loop_i <= 1'b0;
		bus(1'b1, ADDR_CTRL, 32'h0A, 32'h0);
		link_ok_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({31'h0, good_link_o}, 32'h1);
		eq_coef_i <= 18'h00100;
		repeat (2) @(posedge clk_i);
		chk({30'h0, good_link_o, link_enable_o}, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		final_report();
	end
endmodule
